/* core/ascp_device.sv */
// Device end: the converter's serial frame logic, sampled into the core clock.
`timescale 1ns/100ps
// Operation
// RQ1: Select falling: hold, convert, enable output.
// RQ2: Frame is sixteen serial clock cycles.
// RQ3: Track again on fourteenth falling edge.
// RQ4: Mask-write frame holds until select rises.
// RQ5: Output floats on sixteenth falling edge.
// RQ6: Early select rise aborts, register unchanged.
// RQ7: Word is zero, channel tag, result.
// RQ8: Zero at select fall, tag MSB first.
// RQ9: Last bit driven fifteenth, valid sixteenth.
// RQ10: Write flag set: capture twelve control bits.
// RQ11: Mask frame captures all sixteen bits.
// RQ12: Single sequence: host zeroes low byte.
// RQ13: Mask loads at select rise, tracks first.
// RQ14: Result width 8/10/12 padded with zeros.
// RQ15: Serial clock times conversion and data.
// RQ16: Host frames at equal intervals; here a frame starts only on each CMD start write.
// RQ17: Host port: 16-bit, framed, own clock.
// RQ18: Mask frame only after seq0, mask1 write.
// RQ19: Control frame ignores edges thirteen to sixteen.
module ascp_device (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    ascp_if.device pins,
    input wire logic [11:0] conv_data_i,
    output logic [2:0] channel_o,
    output logic tracking_o,
    output logic frame_active_o,
    output logic [11:0] ctrl_o,
    output logic [15:0] shadow_o
);
    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_q;
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_q;
        logic din_s1;
        logic din_s2;
        logic active;
        logic hold;
        logic shadow_frame;
        logic shadow_pending;
        logic [4:0] edges;
        logic [15:0] in_sh;
        logic [14:0] out_sh;
        logic dout;
        logic dout_oe;
        logic [11:0] ctrl;
        logic [15:0] shadow;
        logic [2:0] channel;
    } ascp_dev_state_t;

    ascp_dev_state_t r;
    ascp_dev_state_t nxt;

    // Next channel of the sequence after cur, searching upward with wrap.
    function automatic logic [2:0] next_seq(input logic [7:0] mask, input logic [2:0] cur);
        logic [2:0] pick;
        logic found;
        logic [2:0] cand;
        pick = cur;
        found = 1'b0;
        for (int i = 1; i <= 8; i++) begin
            cand = 3'(cur + 3'(i));
            if (!found && mask[cand]) begin
                pick = cand;
                found = 1'b1;
            end
        end

        return pick;
    endfunction : next_seq

    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;
    logic [4:0] edge_n;
    logic [15:0] in_n;
    logic [7:0] seq_mask;

    always_comb begin
        nxt = r;
        nxt.cs_s1 = pins.cs_n;
        nxt.cs_s2 = r.cs_s1;
        nxt.cs_q = r.cs_s2;

        nxt.sclk_s1 = pins.sclk;
        nxt.sclk_s2 = r.sclk_s1;
        nxt.sclk_q = r.sclk_s2;

        nxt.din_s1 = pins.din;
        nxt.din_s2 = r.din_s1;

        // Edges come from the two later stages, never from the first.
        cs_fall = r.cs_q & ~r.cs_s2;
        cs_rise = ~r.cs_q & r.cs_s2;
        // RQ15 serial clock timing
        sclk_fall = r.sclk_q & ~r.sclk_s2;
        edge_n = 5'(r.edges + 5'h01);
        in_n = {r.in_sh[14:0], r.din_s2};
        seq_mask = r.shadow[15:ascp_pkg::SEQ_MASK_LSB];

        // A clock fall seen together with a select edge is dropped.
        if (cs_fall) begin
            // RQ1 hold and enable output
            nxt.active = 1'b1;
            nxt.hold = 1'b1;
            nxt.dout_oe = 1'b1;
            nxt.edges = 5'h00;
            nxt.in_sh = 16'h0000;
            // RQ8 leading zero at select fall
            nxt.dout = 1'b0;
            // RQ7 RQ14 tag then padded result
            nxt.out_sh = {r.channel, conv_data_i & ascp_pkg::RES_MASK};
            // RQ11 RQ18 routing chosen by the previous write
            nxt.shadow_frame = r.shadow_pending;
            nxt.shadow_pending = 1'b0;
        end else if (cs_rise) begin
            nxt.active = 1'b0;
            nxt.dout_oe = 1'b0;
            nxt.dout = 1'b0;
            nxt.shadow_frame = 1'b0;
            if (r.edges < ascp_pkg::FRAME_EDGES) begin
                // RQ6 abort without register update
                nxt.hold = 1'b0;
                // Mask routing survives so a retried frame still loads the mask.
                nxt.shadow_pending = r.shadow_frame;
            end else if (r.shadow_frame) begin
                // RQ13 mask loads, track first channel
                nxt.shadow = r.in_sh;
                nxt.hold = 1'b0;
                // Starting the search at channel 7 finds the lowest enabled one.
                nxt.channel = next_seq(r.in_sh[15:ascp_pkg::SEQ_MASK_LSB], 3'h7);
            end
        end else if (sclk_fall && r.active && r.edges < ascp_pkg::FRAME_EDGES) begin
            // RQ2 count sixteen falling edges
            nxt.edges = edge_n;
            nxt.in_sh = in_n;
            if (edge_n <= ascp_pkg::LAST_DATA_EDGE) begin
                // RQ8 RQ9 one bit per falling edge
                nxt.dout = r.out_sh[14];
                nxt.out_sh = {r.out_sh[13:0], 1'b0};
            end else begin
                // RQ5 float on sixteenth edge
                nxt.dout_oe = 1'b0;
                nxt.dout = 1'b0;
            end

            // RQ3 RQ4 track again unless mask frame
            if (edge_n == ascp_pkg::HOLD_EDGE && !r.shadow_frame) begin
                nxt.hold = 1'b0;
            end

            // Committing only at the last edge leaves the registers intact on abort.
            if (edge_n == ascp_pkg::FRAME_EDGES && !r.shadow_frame) begin
                if (in_n[15]) begin
                    // RQ10 RQ19 only the first twelve bits count
                    nxt.ctrl = in_n[15:4];
                    // RQ18 mask frame needs seq off, mask select on
                    nxt.shadow_pending = ~in_n[4 + ascp_pkg::CTRL_SEQ_POS] &
                        in_n[4 + ascp_pkg::CTRL_SHADOW_POS];
                    if (in_n[4 + ascp_pkg::CTRL_SEQ_POS]) begin
                        nxt.channel = next_seq(seq_mask, r.channel);
                    end else begin
                        nxt.channel = in_n[4 + ascp_pkg::CTRL_ADDR_LSB +: 3];
                    end
                end else if (r.ctrl[ascp_pkg::CTRL_SEQ_POS]) begin
                    nxt.channel = next_seq(seq_mask, r.channel);
                end
            end
        end
    end

    // Select and clock synchronisers start idle-high so no false select edge appears after reset.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '{
                cs_s1: 1'b1, cs_s2: 1'b1, cs_q: 1'b1,
                sclk_s1: 1'b1, sclk_s2: 1'b1, sclk_q: 1'b1,
                din_s1: 1'b0, din_s2: 1'b0,
                active: 1'b0, hold: 1'b0,
                shadow_frame: 1'b0, shadow_pending: 1'b0,
                edges: 5'h00, in_sh: 16'h0000, out_sh: 15'h0000,
                dout: 1'b0, dout_oe: 1'b0,
                ctrl: ascp_pkg::CTRL_RESET,
                shadow: ascp_pkg::SHADOW_RESET,
                channel: ascp_pkg::CHAN_RESET
            };
        end else begin
            r <= nxt;
        end
    end

    // The output reaches the pin some core cycles after the serial edge;
    // the host's half period must cover the synchroniser latency.
    assign pins.dout = r.dout;
    assign pins.dout_oe = r.dout_oe;

    assign channel_o = r.channel;
    assign tracking_o = ~r.hold;
    assign frame_active_o = r.active;
    assign ctrl_o = r.ctrl;
    assign shadow_o = r.shadow;
endmodule : ascp_device

/* core/ascp_host.sv */
// Host end: AXI4-Lite controlled frame generator driving the converter port.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
module ascp_host (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    ascp_if.host pins,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    typedef struct packed {
        ascp_pkg::ascp_host_state_t st;
        logic [7:0] tmr;
        logic [4:0] bits;
        logic cs_n;
        logic sclk;
        logic din;
        logic [15:0] tx;
        logic [15:0] tx_sh;
        logic [15:0] rx_sh;
        logic [15:0] rx;
        logic done;
        logic dout_s1;
        logic dout_s2;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ascp_host_reg_t;

    ascp_host_reg_t r;
    ascp_host_reg_t nxt;
    logic do_write;
    logic start;
    logic abort;
    logic done_clr;

    always_comb begin
        nxt = r;
        nxt.dout_s1 = pins.dout;
        nxt.dout_s2 = r.dout_s1;
        start = 1'b0;
        abort = 1'b0;
        done_clr = 1'b0;

        // Address and data are taken in either order; the write lands once both are held.
        if (s_axi_awvalid_i && !r.aw_got) begin
            nxt.aw_got = 1'b1;
            nxt.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !r.w_got) begin
            nxt.w_got = 1'b1;
            nxt.w_data = s_axi_wdata_i;
            nxt.w_strb = s_axi_wstrb_i;
        end
        do_write = r.aw_got && r.w_got && !r.bvalid;
        if (do_write) begin
            nxt.aw_got = 1'b0;
            nxt.w_got = 1'b0;
            nxt.bvalid = 1'b1;
            nxt.bresp = ascp_pkg::RESP_OKAY;
            if (r.aw_addr[7:2] == ascp_pkg::REG_CMD[7:2]) begin
                start = r.w_strb[0] & r.w_data[ascp_pkg::CMD_START_POS];
                abort = r.w_strb[0] & r.w_data[ascp_pkg::CMD_ABORT_POS];
            end else if (r.aw_addr[7:2] == ascp_pkg::REG_TX[7:2]) begin
                if (r.w_strb[0]) begin
                    nxt.tx[7:0] = r.w_data[7:0];
                end
                if (r.w_strb[1]) begin
                    nxt.tx[15:8] = r.w_data[15:8];
                end
            end else if (r.aw_addr[7:2] == ascp_pkg::REG_STAT[7:2]) begin
                done_clr = r.w_strb[0] & r.w_data[ascp_pkg::STAT_DONE_POS];
            end else if (r.aw_addr[7:2] != ascp_pkg::REG_RX[7:2]) begin
                nxt.bresp = ascp_pkg::RESP_SLVERR;
            end
        end
        if (r.bvalid && s_axi_bready_i) begin
            nxt.bvalid = 1'b0;
        end

        if (r.rvalid && s_axi_rready_i) begin
            nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid_i && !r.rvalid) begin
            nxt.rvalid = 1'b1;
            nxt.rresp = ascp_pkg::RESP_OKAY;
            nxt.rdata = 32'h0000_0000;
            if (s_axi_araddr_i[7:2] == ascp_pkg::REG_TX[7:2]) begin
                nxt.rdata[15:0] = r.tx;
            end else if (s_axi_araddr_i[7:2] == ascp_pkg::REG_RX[7:2]) begin
                nxt.rdata[15:0] = r.rx;
            end else if (s_axi_araddr_i[7:2] == ascp_pkg::REG_STAT[7:2]) begin
                nxt.rdata[ascp_pkg::STAT_BUSY_POS] = (r.st != ascp_pkg::ASCP_H_IDLE);
                nxt.rdata[ascp_pkg::STAT_DONE_POS] = r.done;
            end else if (s_axi_araddr_i[7:2] != ascp_pkg::REG_CMD[7:2]) begin
                nxt.rresp = ascp_pkg::RESP_SLVERR;
            end
        end

        if (done_clr) begin
            nxt.done = 1'b0;
        end
        nxt.tmr = (r.tmr != 8'h00) ? 8'(r.tmr - 8'h01) : 8'h00;
        case (r.st)
            ascp_pkg::ASCP_H_IDLE: begin
                if (start) begin
                    // RQ2 RQ16 RQ17 open a fixed-length sixteen-bit active-low frame
                    nxt.st = ascp_pkg::ASCP_H_SETUP;
                    nxt.cs_n = 1'b0;
                    nxt.din = r.tx[15];
                    nxt.tx_sh = {r.tx[14:0], 1'b0};
                    nxt.bits = 5'h00;
                    nxt.tmr = 8'(ascp_pkg::SCLK_HALF_CYC - 8'h01);
                end
            end
            ascp_pkg::ASCP_H_SETUP, ascp_pkg::ASCP_H_HIGH: begin
                if (r.tmr == 8'h00) begin
                    if (r.bits == ascp_pkg::FRAME_EDGES) begin
                        nxt.st = ascp_pkg::ASCP_H_QUIET;
                        nxt.cs_n = 1'b1;
                        nxt.rx = r.rx_sh;
                        nxt.done = 1'b1;
                        nxt.tmr = 8'(ascp_pkg::QUIET_CYC - 8'h01);
                    end else begin
                        // Sample just before the fall, while the previous bit still stands.
                        nxt.st = ascp_pkg::ASCP_H_LOW;
                        nxt.sclk = 1'b0;
                        nxt.rx_sh = {r.rx_sh[14:0], r.dout_s2};
                        nxt.bits = 5'(r.bits + 5'h01);
                        nxt.tmr = 8'(ascp_pkg::SCLK_HALF_CYC - 8'h01);
                    end
                end
            end
            ascp_pkg::ASCP_H_LOW: begin
                if (r.tmr == 8'h00) begin
                    // Data changes on the rising edge, away from the device's sampling edge.
                    nxt.st = ascp_pkg::ASCP_H_HIGH;
                    nxt.sclk = 1'b1;
                    nxt.din = r.tx_sh[15];
                    nxt.tx_sh = {r.tx_sh[14:0], 1'b0};
                    nxt.tmr = 8'(ascp_pkg::SCLK_HALF_CYC - 8'h01);
                end
            end
            ascp_pkg::ASCP_H_QUIET: begin
                if (r.tmr == 8'h00) begin
                    nxt.st = ascp_pkg::ASCP_H_IDLE;
                end
            end
            default: begin
                nxt.st = ascp_pkg::ASCP_H_IDLE;
            end
        endcase
        if (abort && r.st != ascp_pkg::ASCP_H_IDLE && r.st != ascp_pkg::ASCP_H_QUIET) begin
            nxt.st = ascp_pkg::ASCP_H_QUIET;
            nxt.cs_n = 1'b1;
            nxt.sclk = 1'b1;
            nxt.tmr = 8'(ascp_pkg::QUIET_CYC - 8'h01);
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '{
                st: ascp_pkg::ASCP_H_IDLE, tmr: 8'h00, bits: 5'h00,
                cs_n: 1'b1, sclk: 1'b1, din: 1'b0,
                tx: 16'h0000, tx_sh: 16'h0000, rx_sh: 16'h0000, rx: 16'h0000,
                done: 1'b0, dout_s1: 1'b0, dout_s2: 1'b0,
                aw_got: 1'b0, aw_addr: 8'h00, w_got: 1'b0,
                w_data: 32'h0000_0000, w_strb: 4'h0,
                bvalid: 1'b0, bresp: 2'h0,
                rvalid: 1'b0, rdata: 32'h0000_0000, rresp: 2'h0
            };
        end else begin
            r <= nxt;
        end
    end

    assign pins.cs_n = r.cs_n;
    assign pins.sclk = r.sclk;
    assign pins.din = r.din;
    assign s_axi_awready_o = ~r.aw_got;
    assign s_axi_wready_o = ~r.w_got;
    assign s_axi_bvalid_o = r.bvalid;
    assign s_axi_bresp_o = r.bresp;
    assign s_axi_arready_o = ~r.rvalid;
    assign s_axi_rvalid_o = r.rvalid;
    assign s_axi_rdata_o = r.rdata;
    assign s_axi_rresp_o = r.rresp;
endmodule : ascp_host

/* core/ascp_if.sv */
// Pin bundle between the converter serial port and its host.
`timescale 1ns/100ps
interface ascp_if;
    logic cs_n;
    logic sclk;
    logic din;
    logic dout;
    logic dout_oe;

    modport device (
        input cs_n,
        input sclk,
        input din,
        output dout,
        output dout_oe
    );

    modport host (
        output cs_n,
        output sclk,
        output din,
        input dout,
        input dout_oe
    );
endinterface : ascp_if

/* core/ascp_pkg.sv */
// Shared constants and types for the converter serial port and its host controller.
package ascp_pkg;
    // Core clock and serial timing.
    localparam int CLK_PERIOD_NS = 20;
    localparam int SCLK_HALF_NS = 160;
    localparam int QUIET_NS = 100;
    localparam logic [7:0] SCLK_HALF_CYC =
        8'((SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] QUIET_CYC = 8'((QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Frame geometry, counted in falling serial clock edges.
    localparam logic [4:0] FRAME_EDGES = 5'h10;
    localparam logic [4:0] LAST_DATA_EDGE = 5'h0f;
    localparam logic [4:0] HOLD_EDGE = 5'h0e;
    localparam int RES_BITS = 12;
    localparam logic [11:0] RES_MASK = 12'hfff << (12 - RES_BITS);

    // Control word layout, bit 11 arrives first.
    localparam int CTRL_WRITE_POS = 11;
    localparam int CTRL_SEQ_POS = 10;
    localparam int CTRL_SHADOW_POS = 9;
    localparam int CTRL_ADDR_LSB = 6;
    localparam int SEQ_MASK_LSB = 8;
    localparam logic [11:0] CTRL_RESET = 12'h000;
    localparam logic [15:0] SHADOW_RESET = 16'h0000;
    localparam logic [2:0] CHAN_RESET = 3'h0;

    // Host controller register map, byte addresses.
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_TX = 8'h04;
    localparam logic [7:0] REG_RX = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0c;
    localparam int CMD_START_POS = 0;
    localparam int CMD_ABORT_POS = 1;
    localparam int STAT_BUSY_POS = 0;
    localparam int STAT_DONE_POS = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ASCP_H_IDLE = 3'h0,
        ASCP_H_SETUP = 3'h1,
        ASCP_H_LOW = 3'h2,
        ASCP_H_HIGH = 3'h3,
        ASCP_H_QUIET = 3'h4
    } ascp_host_state_t;
endpackage : ascp_pkg

/* sim/adc_serial_conversion_port_tb.sv */
// Self-checking bench: host and device joined over the link, driven over AXI4-Lite.
`timescale 1ns/100ps
module adc_serial_conversion_port_tb;
    logic ref_clk_i;
    logic rst_i;
    logic [11:0] conv_data;
    logic [2:0] channel;
    logic tracking;
    logic [11:0] ctrl;
    logic [15:0] shadow;
    logic [7:0] awaddr;
    logic awvalid;
    logic awready;
    logic [31:0] wdata;
    logic wvalid;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready;
    logic sclk_q;
    logic [4:0] falls;
    logic trk_first;
    logic trk_late;
    logic [11:0] exp_ctrl;
    logic [15:0] exp_shadow;
    logic [1:0] resp_v;
    logic [31:0] data_v;
    int exp_chan;
    int error_cnt;
    int cmp_count;
    int cyc;
    int seed;

    ascp_if link();
    ascp_device i_ascp_device (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .pins(link),
        .conv_data_i(conv_data), .channel_o(channel), .tracking_o(tracking),
        .frame_active_o(), .ctrl_o(ctrl), .shadow_o(shadow));
    ascp_host i_ascp_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .pins(link),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
    ascp_assertions i_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cs_n(link.cs_n),
        .sclk(link.sclk), .din(link.din), .dout(link.dout), .dout_oe(link.dout_oe));

    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    // Samples the hold state early and late in each frame, where the device has settled.
    always @(posedge ref_clk_i) begin
        sclk_q <= link.sclk;
        falls <= link.cs_n ? 5'h00 : falls + 5'(sclk_q && !link.sclk);
        if (falls == 5'h01) trk_first <= tracking;
        if (falls == 5'h0f) trk_late <= tracking;
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt = error_cnt + 1;
            final_report();
        end
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge ref_clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge ref_clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        check(32'(r), 32'(ascp_pkg::RESP_OKAY), "bresp");
    endtask : wr_ok

    task automatic rd_ok(input logic [7:0] a, output logic [31:0] d);
        logic [1:0] r;
        axi_rd(a, d, r);
        check(32'(r), 32'(ascp_pkg::RESP_OKAY), "rresp");
    endtask : rd_ok

    task automatic run_frame(input logic [15:0] tx, input bit is_mask);
        logic [11:0] cd;
        logic [31:0] d;
        int nc;
        cd = 12'($random(seed));
        conv_data <= cd;
        wr_ok(ascp_pkg::REG_TX, {16'h0000, tx});
        wr_ok(ascp_pkg::REG_CMD, 32'h1);
        do begin
            rd_ok(ascp_pkg::REG_STAT, d);
        end while (d[ascp_pkg::STAT_DONE_POS] !== 1'b1);
        rd_ok(ascp_pkg::REG_RX, d);
        check(d, {16'h0, 1'b0, 3'(exp_chan), cd & ascp_pkg::RES_MASK}, "word");
        check(32'(trk_first), 32'h0, "hold");
        check(32'(trk_late), 32'(!is_mask), "late track");
        if (is_mask) begin
            exp_shadow = tx;
            // The caller sets the lowest mask bit, so channel 0 leads.
            exp_chan = 0;
        end else begin
            if (tx[15]) exp_ctrl = tx[15:4];
            nc = (tx[15] && !exp_ctrl[10]) ? int'(tx[12:10]) : exp_chan;
            // Sequencer on: next enabled channel above the current one, wrapping.
            for (int k = 7; exp_ctrl[10] && k >= 1; k--) begin
                if (exp_shadow[8 + (exp_chan + k) % 8]) nc = (exp_chan + k) % 8;
            end
            exp_chan = nc;
        end
        repeat (4) @(posedge ref_clk_i);
        check(32'(ctrl), 32'(exp_ctrl), "ctrl");
        check(32'(shadow), 32'(exp_shadow), "mask");
        check(32'(tracking), 32'h1, "track after");
        check(32'(channel), 32'(exp_chan), "chan");
        wr_ok(ascp_pkg::REG_STAT, 32'h2);
    endtask : run_frame

    initial begin
        seed = 21762;
        rst_i = 1'b1;
        conv_data = 12'h000;
        {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
        {sclk_q, falls, trk_first, trk_late} = {1'b1, 5'h00, 2'b00};
        {exp_ctrl, exp_shadow, exp_chan, error_cnt, cmp_count, cyc} = '0;
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        check({ctrl, shadow, tracking, link.cs_n, link.sclk, link.dout_oe}, 32'he, "reset");
        rd_ok(ascp_pkg::REG_STAT, data_v);
        check(data_v, 32'h0, "stat reset");
        axi_wr(8'h10, 32'h1, resp_v);
        check(32'(resp_v), 32'(ascp_pkg::RESP_SLVERR), "unmapped write");
        axi_rd(8'h10, data_v, resp_v);
        check(32'(resp_v), 32'(ascp_pkg::RESP_SLVERR), "unmapped read");
        // Every channel address, with random trailing bits; the last four must be ignored.
        for (int i = 0; i < 9; i++) begin
            run_frame({1'b1, 2'b00, 3'(i), 10'($random(seed))}, 1'b0);
        end
        run_frame({1'b0, 15'($random(seed))}, 1'b0);
        // Abort a frame that would have enabled the sequencer.
        wr_ok(ascp_pkg::REG_TX, 32'h0000fff0);
        wr_ok(ascp_pkg::REG_CMD, 32'h1);
        repeat (100) @(posedge ref_clk_i);
        wr_ok(ascp_pkg::REG_CMD, 32'h2);
        repeat (10) @(posedge ref_clk_i);
        check({link.dout_oe, tracking, 18'h0, ctrl}, {2'b01, 18'h0, exp_ctrl}, "abort");
        rd_ok(ascp_pkg::REG_STAT, data_v);
        check(data_v & 32'h2, 32'h0, "no done");
        run_frame({1'b1, 2'b01, 3'(exp_chan), 10'h000}, 1'b0);
        run_frame({8'($random(seed)) | 8'h01, 8'h00}, 1'b1);
        run_frame(16'hc000, 1'b0);
        run_frame(16'h0000, 1'b0);
        final_report();
    end
endmodule : adc_serial_conversion_port_tb

/* sim/ascp_assertions.sv */
// Pin-level checker for the link between the converter port and its host.
`timescale 1ns/100ps
module ascp_assertions (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe
);
    logic sclk_q_r;
    logic [4:0] fall_cnt_r;

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // Counts serial clock falls of the current frame; a high select clears it.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_q_r <= 1'b1;
            fall_cnt_r <= 5'h00;
        end else begin
            sclk_q_r <= sclk;
            if (cs_n) begin
                fall_cnt_r <= 5'h00;
            end else if (sclk_q_r && !sclk) begin
                fall_cnt_r <= fall_cnt_r + 5'h01;
            end
        end
    end

    property p_oe_on;
        $fell(cs_n) |-> ##[3:6] dout_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("output not enabled after select fall");
    property p_zero_lead;
        $rose(dout_oe) |-> !dout && !cs_n;
    endproperty
    a_zero_lead: assert property (p_zero_lead) else $error("first bit is not zero");
    property p_oe_kept;
        ($fell(sclk) && fall_cnt_r == 5'h0e) |-> dout_oe [*8];
    endproperty
    a_oe_kept: assert property (p_oe_kept) else $error("output dropped before last bit");
    property p_oe_off_last;
        ($fell(sclk) && fall_cnt_r == 5'h0f) |-> dout_oe ##[3:6] !dout_oe;
    endproperty
    a_oe_off_last: assert property (p_oe_off_last) else $error("output still on");
    property p_oe_off_early;
        $rose(cs_n) |-> ##[3:6] !dout_oe;
    endproperty
    a_oe_off_early: assert property (p_oe_off_early) else $error("output on after select");
    property p_dout_stand;
        ($rose(sclk) && !cs_n && dout_oe) |-> $stable(dout) [*8];
    endproperty
    a_dout_stand: assert property (p_dout_stand) else $error("data moved off a fall");
    property p_fall_limit;
        $fell(sclk) |-> !cs_n && fall_cnt_r < 5'h10;
    endproperty
    a_fall_limit: assert property (p_fall_limit) else $error("clock fall outside frame");
    property p_din_hold;
        ($fell(sclk) && !cs_n) |=> (cs_n || $stable(din)) [*6];
    endproperty
    a_din_hold: assert property (p_din_hold) else $error("input bit moved while low");
    property p_idle_high;
        cs_n |-> sclk;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("clock low outside frame");

    c_full: cover property ($rose(cs_n) && fall_cnt_r == 5'h10);
    c_abort: cover property ($rose(cs_n) && fall_cnt_r != 5'h10);
    c_track: cover property ($fell(sclk) && fall_cnt_r == 5'h0d);
endmodule : ascp_assertions
